// *** src/otps_host.sv ***
`timescale 1ns/1ps
`include "otps_regs.svh"
// Operation
// - Write unlock key to key register first
// - Stage data word before start
// - Write burn current code to control
// - Write target register number to address
// - Write start command to begin burn
// - Wait burn time before next operation
// - One address per start, restage each
// - Clear staging registers after burning ends
// - Verify: key, then verify current code
// - Verify: enable nonvolatile readback register
// - Read target back and compare intent
// - Frame address shifted left two bits
// - Stay silent during power-up load
module otps_host
   import otps_pkg::*;
#(
   parameter int unsigned PWRUP_CYC = `OTPS_PWRUP_CYC,
   parameter int unsigned BURN_CYC  = `OTPS_BURN_CYC,
   parameter int          HALF      = `OTPS_SCK_HALF_CYC,
   parameter logic [7:0]  WR_CMD    = 8'h40,
   parameter logic [7:0]  RD_CMD    = 8'h50
) (
   // Clock, reset, enable
   input  wire logic       mclk,
   input  wire logic       resetn,
   input  wire logic       ce,
   // User order
   input  wire logic       op_valid,
   input  wire otps_op_e   op_kind,
   input  wire logic [5:0] op_addr,
   input  wire logic [15:0] op_data,
   output logic            op_ready_ff,
   // User result
   output logic            done_ff,
   output logic            match_ff,
   output logic [15:0]     rd_data_ff,
   // Device pins
   output logic            spi_csn,
   output logic            spi_sclk,
   output logic            spi_mosi,
   input  wire logic       spi_miso
);
   otps_state_e st_ff;
   otps_op_e    op_ff;
   logic [5:0]  tgt_ff;
   logic [15:0] dat_ff;
   logic [2:0]  step_ff;
   logic [31:0] wait_ff;
   logic        spi_start_ff;
   logic        spi_done;
   logic [15:0] spi_rx;
   logic [5:0]  s_addr;
   logic [15:0] s_data;
   logic        s_rd;
   logic [2:0]  s_last;
   logic [`OTPS_FRAME_BITS-1:0] frame_tx;

   // ==========================================================
   // Step table
   always_comb begin
      s_addr = `OTPS_REG_KEY;
      s_data = `OTPS_KEY_VAL;
      s_rd   = 1'b0;
      s_last = 3'h3;
      case (op_ff)
         OTPS_OP_BURN: begin
            s_last = 3'h4;
            case (step_ff)
               3'h0: begin
                  s_addr = `OTPS_REG_KEY;
                  s_data = `OTPS_KEY_VAL;
               end
               3'h1: begin
                  s_addr = `OTPS_REG_DATA;
                  s_data = dat_ff;
               end
               3'h2: begin
                  s_addr = `OTPS_REG_MODE;
                  s_data = `OTPS_MODE_BURN;
               end
               3'h3: begin
                  s_addr = `OTPS_REG_TARGET;
                  s_data = {10'h000, tgt_ff};
               end
               default: begin
                  s_addr = `OTPS_REG_START;
                  s_data = `OTPS_START_VAL;
               end
            endcase
         end
         OTPS_OP_VERIFY: begin
            case (step_ff)
               3'h0: begin
                  s_addr = `OTPS_REG_KEY;
                  s_data = `OTPS_KEY_VAL;
               end
               3'h1: begin
                  s_addr = `OTPS_REG_MODE;
                  s_data = `OTPS_MODE_VERIFY;
               end
               3'h2: begin
                  s_addr = `OTPS_REG_VERIFY;
                  s_data = `OTPS_VERIFY_VAL;
               end
               default: begin
                  s_addr = tgt_ff;
                  s_data = 16'h0000;
                  s_rd   = 1'b1;
               end
            endcase
         end
         default: begin
            // Walk 9 up to 12, writing zero
            s_addr = `OTPS_REG_MODE + {3'h0, step_ff};
            s_data = `OTPS_CLEAR_VAL;
         end
      endcase
   end

   assign frame_tx = {s_rd ? RD_CMD : WR_CMD,
                      s_addr, 2'b00,
                      s_data};

   // ==========================================================
   // Sequencer
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         st_ff        <= ST_PWRUP;
         wait_ff      <= 32'(PWRUP_CYC - 1);
         op_ready_ff  <= 1'b0;
         spi_start_ff <= 1'b0;
         step_ff      <= 3'h0;
         done_ff      <= 1'b0;
      end else if (ce) begin
         spi_start_ff <= 1'b0;
         done_ff      <= 1'b0;
         case (st_ff)
            ST_PWRUP: begin
               if (wait_ff == 32'h0) begin
                  st_ff       <= ST_IDLE;
                  op_ready_ff <= 1'b1;
               end else begin
                  wait_ff <= wait_ff - 32'h1;
               end
            end
            ST_IDLE: begin
               if (op_valid) begin
                  op_ready_ff <= 1'b0;
                  step_ff     <= 3'h0;
                  st_ff       <= ST_SEND;
               end
            end
            ST_SEND: begin
               spi_start_ff <= 1'b1;
               st_ff        <= ST_WAITSPI;
            end
            ST_WAITSPI: begin
               if (spi_done) begin
                  if (step_ff != s_last) begin
                     step_ff <= step_ff + 3'h1;
                     st_ff   <= ST_SEND;
                  end else if (op_ff == OTPS_OP_BURN) begin
                     wait_ff <= 32'(BURN_CYC - 1);
                     st_ff   <= ST_BURNWAIT;
                  end else begin
                     st_ff <= ST_FIN;
                  end
               end
            end
            ST_BURNWAIT: begin
               if (wait_ff == 32'h0) begin
                  st_ff <= ST_FIN;
               end else begin
                  wait_ff <= wait_ff - 32'h1;
               end
            end
            ST_FIN: begin
               // Ready only after the whole sequence; one address each
               done_ff     <= 1'b1;
               op_ready_ff <= 1'b1;
               st_ff       <= ST_IDLE;
            end
            default: st_ff <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Order latch, held for the whole sequence
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         op_ff  <= OTPS_OP_BURN;
         tgt_ff <= 6'h00;
         dat_ff <= 16'h0000;
      end else if (ce && st_ff == ST_IDLE && op_valid) begin
         op_ff  <= op_kind;
         tgt_ff <= op_addr;
         dat_ff <= op_data;
      end
   end

   // ==========================================================
   // Readback and compare
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         rd_data_ff <= 16'h0000;
         match_ff   <= 1'b0;
      end else if (ce && st_ff == ST_WAITSPI && spi_done && s_rd) begin
         rd_data_ff <= spi_rx;
         match_ff   <= (spi_rx == dat_ff);
      end
   end

   otps_spi #(
      .NBITS (`OTPS_FRAME_BITS),
      .HALF  (HALF)
   ) u_spi (
      .mclk    (mclk),
      .resetn  (resetn),
      .ce      (ce),
      .start   (spi_start_ff),
      .tx      (frame_tx),
      .done_ff (spi_done),
      .rx_ff   (spi_rx),
      .csn_ff  (spi_csn),
      .sclk_ff (spi_sclk),
      .mosi_ff (spi_mosi),
      .miso    (spi_miso)
   );

   // ==========================================================
   // Checks
   logic [31:0] burn_cnt_ff;
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         burn_cnt_ff <= 32'h0;
      end else if (ce) begin
         burn_cnt_ff <= (st_ff == ST_BURNWAIT) ? burn_cnt_ff + 32'h1 : 32'h0;
      end
   end

   sequence s_frame_go;
      spi_start_ff;
   endsequence

   property p_quiet_pwrup;
      @(posedge mclk) disable iff (!resetn)
      st_ff == ST_PWRUP |-> spi_csn && !op_ready_ff;
   endproperty
   a_quiet_pwrup: assert property (p_quiet_pwrup)
      else $error("bus active during power-up load");

   property p_key_first;
      @(posedge mclk) disable iff (!resetn)
      s_frame_go and (step_ff == 3'h0 && op_ff != OTPS_OP_CLEAR)
      |-> frame_tx[23:18] == `OTPS_REG_KEY && frame_tx[15:0] == `OTPS_KEY_VAL;
   endproperty
   a_key_first: assert property (p_key_first)
      else $error("first frame is not the unlock key");

   property p_stage_data;
      @(posedge mclk) disable iff (!resetn)
      s_frame_go and (op_ff == OTPS_OP_BURN && step_ff == 3'h1)
      |-> frame_tx[23:18] == `OTPS_REG_DATA && frame_tx[15:0] == dat_ff;
   endproperty
   a_stage_data: assert property (p_stage_data)
      else $error("data word not staged");

   property p_burn_current;
      @(posedge mclk) disable iff (!resetn)
      s_frame_go and (op_ff == OTPS_OP_BURN && step_ff == 3'h2)
      |-> frame_tx[23:18] == `OTPS_REG_MODE && frame_tx[15:0] == `OTPS_MODE_BURN;
   endproperty
   a_burn_current: assert property (p_burn_current)
      else $error("burn current code wrong");

   property p_target;
      @(posedge mclk) disable iff (!resetn)
      s_frame_go and (op_ff == OTPS_OP_BURN && step_ff == 3'h3)
      |-> frame_tx[23:18] == `OTPS_REG_TARGET && frame_tx[5:0] == tgt_ff;
   endproperty
   a_target: assert property (p_target)
      else $error("target address frame wrong");

   property p_start;
      @(posedge mclk) disable iff (!resetn)
      s_frame_go and (op_ff == OTPS_OP_BURN && step_ff == 3'h4)
      |-> frame_tx[23:18] == `OTPS_REG_START && frame_tx[15:0] == `OTPS_START_VAL;
   endproperty
   a_start: assert property (p_start)
      else $error("start frame wrong");

   property p_burn_wait;
      @(posedge mclk) disable iff (!resetn)
      (st_ff == ST_BURNWAIT) ##1 (st_ff != ST_BURNWAIT)
      |-> $past(burn_cnt_ff) == 32'(BURN_CYC - 1);
   endproperty
   a_burn_wait: assert property (p_burn_wait)
      else $error("burn wait cut short");

   property p_hold_order;
      @(posedge mclk) disable iff (!resetn)
      !op_ready_ff && $past(!op_ready_ff) |-> $stable(tgt_ff) && $stable(dat_ff);
   endproperty
   a_hold_order: assert property (p_hold_order)
      else $error("order changed during sequence");

   property p_clear;
      @(posedge mclk) disable iff (!resetn)
      s_frame_go and (op_ff == OTPS_OP_CLEAR)
      |-> frame_tx[15:0] == 16'h0000 && frame_tx[23:18] >= `OTPS_REG_MODE
          && frame_tx[23:18] <= `OTPS_REG_KEY;
   endproperty
   a_clear: assert property (p_clear)
      else $error("clear frame wrong");

   property p_verify_enable;
      @(posedge mclk) disable iff (!resetn)
      s_frame_go and (op_ff == OTPS_OP_VERIFY && step_ff == 3'h2)
      |-> frame_tx[23:18] == `OTPS_REG_VERIFY && frame_tx[15:0] == `OTPS_VERIFY_VAL;
   endproperty
   a_verify_enable: assert property (p_verify_enable)
      else $error("readback enable frame wrong");

   property p_compare;
      @(posedge mclk) disable iff (!resetn)
      done_ff && op_ff == OTPS_OP_VERIFY |-> match_ff == (rd_data_ff == dat_ff);
   endproperty
   a_compare: assert property (p_compare)
      else $error("compare result wrong");

   property p_shift;
      @(posedge mclk) disable iff (!resetn)
      s_frame_go |-> frame_tx[17:16] == 2'b00;
   endproperty
   a_shift: assert property (p_shift)
      else $error("address not shifted");
endmodule : otps_host

// *** pkg/otps_regs.svh ***
`ifndef OTPS_REGS_SVH
`define OTPS_REGS_SVH
// ==========================================================
// Device register offsets (word addresses before the shift)
`define OTPS_REG_VERIFY   6'h07
`define OTPS_REG_START    6'h08
`define OTPS_REG_MODE     6'h09
`define OTPS_REG_TARGET   6'h0a
`define OTPS_REG_DATA     6'h0b
`define OTPS_REG_KEY      6'h0c
// ==========================================================
// Register values
`define OTPS_KEY_VAL      16'h3337
`define OTPS_MODE_BURN    16'h0043
`define OTPS_MODE_VERIFY  16'h0050
`define OTPS_START_VAL    16'h0001
`define OTPS_VERIFY_VAL   16'h0001
`define OTPS_CLEAR_VAL    16'h0000
// ==========================================================
// Frame layout: command, shifted address, data
`define OTPS_FRAME_BITS   32
`define OTPS_ADDR_SHIFT   2
// ==========================================================
// Timing
`define OTPS_CLK_KHZ      10000
`define OTPS_PWRUP_US     4000
`define OTPS_BURN_US      1600
`define OTPS_PWRUP_CYC    ((`OTPS_PWRUP_US * `OTPS_CLK_KHZ + 999) / 1000)
`define OTPS_BURN_CYC     ((`OTPS_BURN_US * `OTPS_CLK_KHZ + 999) / 1000)
`define OTPS_SCK_HALF_CYC 4
`endif

// *** pkg/otps_pkg.sv ***
package otps_pkg;
   typedef enum logic [1:0] {OTPS_OP_BURN, OTPS_OP_VERIFY, OTPS_OP_CLEAR} otps_op_e;
   typedef enum logic [2:0] {
      ST_PWRUP, ST_IDLE, ST_SEND, ST_WAITSPI, ST_BURNWAIT, ST_FIN
   } otps_state_e;
   typedef enum logic [2:0] {
      SP_IDLE, SP_LEAD, SP_LOW, SP_HIGH, SP_TRAIL
   } otps_spi_e;
endpackage : otps_pkg

// *** src/otps_spi.sv ***
`timescale 1ns/1ps
`include "otps_regs.svh"
module otps_spi
   import otps_pkg::*;
#(
   parameter int NBITS = `OTPS_FRAME_BITS,
   parameter int HALF  = `OTPS_SCK_HALF_CYC
) (
   // Clock, reset, enable
   input  wire logic             mclk,
   input  wire logic             resetn,
   input  wire logic             ce,
   // Frame request
   input  wire logic             start,
   input  wire logic [NBITS-1:0] tx,
   output logic                  done_ff,
   output logic [15:0]           rx_ff,
   // Pins, SPI mode 3
   output logic                  csn_ff,
   output logic                  sclk_ff,
   output logic                  mosi_ff,
   input  wire logic             miso
);
   localparam logic [7:0] HALF_M1 = 8'(HALF - 1);
   localparam logic [5:0] LAST    = 6'(NBITS - 1);

   otps_spi_e        st_ff;
   logic [7:0]       div_ff;
   logic [5:0]       bit_ff;
   logic [NBITS-1:0] sh_ff;
   logic             s1_ff, s2_ff, s3_ff, miso_ff;
   logic             tick;

   assign tick = (div_ff == HALF_M1);

   // ==========================================================
   // Input synchroniser; change taken once stages 2 and 3 agree
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         s1_ff   <= 1'b0;
         s2_ff   <= 1'b0;
         s3_ff   <= 1'b0;
         miso_ff <= 1'b0;
      end else if (ce) begin
         s1_ff <= miso;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (s2_ff == s3_ff) begin
            miso_ff <= s3_ff;
         end
      end
   end

   // ==========================================================
   // Shifter: data out on falling edge, sampled before next fall
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         st_ff   <= SP_IDLE;
         div_ff  <= 8'h00;
         bit_ff  <= 6'h00;
         sh_ff   <= '0;
         rx_ff   <= 16'h0000;
         csn_ff  <= 1'b1;
         sclk_ff <= 1'b1;
         mosi_ff <= 1'b0;
         done_ff <= 1'b0;
      end else if (ce) begin
         done_ff <= 1'b0;
         div_ff  <= tick ? 8'h00 : div_ff + 8'h01;
         case (st_ff)
            SP_IDLE: begin
               div_ff <= 8'h00;
               if (start) begin
                  sh_ff  <= tx;
                  bit_ff <= 6'h00;
                  csn_ff <= 1'b0;
                  st_ff  <= SP_LEAD;
               end
            end
            SP_LEAD: if (tick) begin
               sclk_ff <= 1'b0;
               mosi_ff <= sh_ff[NBITS-1];
               sh_ff   <= {sh_ff[NBITS-2:0], 1'b0};
               st_ff   <= SP_LOW;
            end
            SP_LOW: if (tick) begin
               sclk_ff <= 1'b1;
               st_ff   <= SP_HIGH;
            end
            SP_HIGH: if (tick) begin
               rx_ff <= {rx_ff[14:0], miso_ff};
               if (bit_ff == LAST) begin
                  st_ff <= SP_TRAIL;
               end else begin
                  sclk_ff <= 1'b0;
                  mosi_ff <= sh_ff[NBITS-1];
                  sh_ff   <= {sh_ff[NBITS-2:0], 1'b0};
                  bit_ff  <= bit_ff + 6'h01;
                  st_ff   <= SP_LOW;
               end
            end
            SP_TRAIL: if (tick) begin
               csn_ff  <= 1'b1;
               mosi_ff <= 1'b0;
               done_ff <= 1'b1;
               st_ff   <= SP_IDLE;
            end
            default: st_ff <= SP_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Checks
   property p_idle_clock_high;
      @(posedge mclk) disable iff (!resetn)
      csn_ff |-> sclk_ff;
   endproperty
   a_idle_clock_high: assert property (p_idle_clock_high)
      else $error("serial clock low while select is inactive");
endmodule : otps_spi

// *** verif/otps_dev_model.sv ***
`timescale 1ns/1ps
`include "otps_regs.svh"
module otps_dev_model #(
   parameter int unsigned PWRUP_CYC = 20,
   parameter int unsigned BURN_CYC  = 30,
   parameter int          DLY_NS    = 100,
   parameter logic [7:0]  WR_CMD    = 8'h40,
   parameter logic [7:0]  RD_CMD    = 8'h50
) (
   // Clock and power
   input  wire logic mclk,
   input  wire logic por_n,
   // Serial pins
   input  wire logic csn,
   input  wire logic sclk,
   input  wire logic mosi,
   output logic      miso
);
   logic [15:0] regs [0:63];
   logic [15:0] otp  [0:63];
   logic [63:0] burned;
   logic [31:0] sh;
   logic [15:0] rword;
   logic [5:0]  a;
   logic        busy, rd, sd, sa;
   int          cnt, cyc, t_start, viol, burns;
   initial begin
      foreach (regs[j]) begin
         regs[j] = 16'h0000;
         otp[j]  = 16'h0000;
      end
      {burned, busy, rd, sd, sa, miso} = '0;
      {cnt, cyc, t_start, viol, burns} = '0;
   end
   // ==========================================
   // Power-up load and burn timer
   always @(posedge mclk) begin
      cyc <= por_n ? cyc + 1 : 0;
      if (busy && cyc - t_start >= BURN_CYC) busy = 1'b0;
      if (csn) miso <= ~miso;
   end
   always @(negedge csn) begin
      cnt = 0;
      if (cyc < PWRUP_CYC) viol++;
      if (busy) viol++;
   end
   // ==========================================
   // Frame shift, readback on falling clock
   always @(posedge sclk) if (!csn) begin
      sh = {sh[30:0], mosi};
      cnt++;
   end
   always @(negedge sclk) if (!csn) begin
      if (cnt == 16) begin
         rd = (sh[15:8] == RD_CMD);
         if (sh[1:0] != 2'b00) viol++;
         rword = (regs[7] == `OTPS_VERIFY_VAL && regs[9] == `OTPS_MODE_VERIFY
                  && regs[12] == `OTPS_KEY_VAL) ? otp[sh[7:2]] : regs[sh[7:2]];
      end
      if (cnt >= 16 && rd) miso <= #(DLY_NS) rword[31-cnt];
      else miso = ~miso;
   end
   // ==========================================
   // Register writes and burn start
   // Select leaving X at power-on is no frame end
   always @(posedge csn) if (por_n) begin
      a = sh[23:18];
      if (cnt != 32 || (sh[31:24] != WR_CMD && sh[31:24] != RD_CMD)) viol++;
      else if (sh[31:24] == WR_CMD) begin
         regs[a] = sh[15:0];
         if (a == `OTPS_REG_DATA) sd = 1'b1;
         if (a == `OTPS_REG_TARGET) sa = 1'b1;
         if (a == `OTPS_REG_START && sh[15:0] == `OTPS_START_VAL) begin
            if (!sd || !sa) viol++;
            if (regs[12] == `OTPS_KEY_VAL && regs[9] == `OTPS_MODE_BURN && !busy) begin
               if (!burned[regs[10][5:0]]) begin
                  otp[regs[10][5:0]]    = regs[11];
                  burned[regs[10][5:0]] = 1'b1;
               end
               burns++;
               busy    = 1'b1;
               t_start = cyc;
               sd      = 1'b0;
               sa      = 1'b0;
            end
         end
      end
   end
endmodule : otps_dev_model

// *** verif/tb.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
   import otps_pkg::*;
   localparam int PW = 20;
   localparam int BN = 30;
   logic        mclk, resetn, ce, op_valid, op_ready_ff, done_ff, match_ff;
   logic        spi_csn, spi_sclk, spi_mosi, spi_miso;
   otps_op_e    op_kind;
   logic [5:0]  op_addr, ra;
   logic [15:0] op_data, rd_data_ff, rdat;
   logic [15:0] exp_otp [0:63];
   logic [63:0] exp_burned;
   logic [5:0]  aq [$];
   int          err_total, check_count, dones, nops, n, i;
   otps_host #(.PWRUP_CYC(PW), .BURN_CYC(BN)) uut (
      .mclk(mclk), .resetn(resetn), .ce(ce), .op_valid(op_valid), .op_kind(op_kind),
      .op_addr(op_addr), .op_data(op_data), .op_ready_ff(op_ready_ff), .done_ff(done_ff),
      .match_ff(match_ff), .rd_data_ff(rd_data_ff), .spi_csn(spi_csn),
      .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso));
   otps_dev_model #(.PWRUP_CYC(PW), .BURN_CYC(BN)) dev (
      .mclk(mclk), .por_n(resetn), .csn(spi_csn), .sclk(spi_sclk),
      .mosi(spi_mosi), .miso(spi_miso));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   always @(posedge mclk) if (done_ff === 1'b1) dones++;
   // ==========================================
   // Expected verify outcome from the burn history
   function automatic logic exp_match(input logic [5:0] a, input logic [15:0] d);
      return exp_otp[a] === d;
   endfunction : exp_match
   // ==========================================
   // Verdict
   task automatic final_report;
      if (err_total == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : final_report
   // ==========================================
   // One order; poke fires refused requests and a ce stall
   task automatic do_op(input otps_op_e k, input logic [5:0] a, input logic [15:0] d,
                        input bit poke);
      int  w;
      logic sk;
      w = 0;
      while (op_ready_ff !== 1'b1 && w < 3000) begin
         @(negedge mclk);
         w++;
      end
      op_kind  = k;
      op_addr  = a;
      op_data  = d;
      op_valid = 1'b1;
      nops++;
      @(negedge mclk);
      op_valid = 1'b0;
      w = 0;
      while (done_ff !== 1'b1 && w < 3000) begin
         op_valid = poke && w < 200 && w[0];
         op_kind  = OTPS_OP_CLEAR;
         ce = !(poke && w >= 300 && w < 305);
         if (w == 300) sk = spi_sclk;
         if (poke && w == 305) `CHK(spi_sclk, sk)
         @(negedge mclk);
         w++;
      end
      `CHK(done_ff, 1'b1)
   endtask : do_op
   task automatic burn(input logic [5:0] a, input logic [15:0] d, input bit poke);
      do_op(OTPS_OP_BURN, a, d, poke);
      if (!exp_burned[a]) begin
         exp_otp[a]    = d;
         exp_burned[a] = 1'b1;
         aq.push_back(a);
      end
   endtask : burn
   task automatic verify(input logic [5:0] a, input logic [15:0] d);
      do_op(OTPS_OP_VERIFY, a, d, 1'b0);
      `CHK(rd_data_ff, exp_otp[a])
      `CHK(match_ff, exp_match(a, d))
   endtask : verify
   // ==========================================
   // Main sequence
   initial begin
      {err_total, check_count, dones, nops} = '0;
      {resetn, op_valid, exp_burned, op_addr, op_data} = '0;
      ce      = 1'b1;
      op_kind = OTPS_OP_BURN;
      foreach (exp_otp[j]) exp_otp[j] = 16'h0000;
      void'($urandom(82103));
      repeat (8) @(negedge mclk);
      `CHK({spi_csn, spi_sclk, spi_mosi, op_ready_ff, done_ff}, 5'b11000)
      resetn = 1'b1;
      n = 0;
      while (op_ready_ff !== 1'b1 && n < 100) begin
         @(negedge mclk);
         n++;
      end
      `CHK(n, PW)
      burn(6'd25, 16'hffff, 1'b1);
      `CHK(dev.burns, 1)
      burn(6'd63, 16'h0000, 1'b0);
      for (i = 0; i < 4; i++) begin
         ra   = 6'($urandom_range(16, 62));
         rdat = 16'($urandom);
         burn(ra, rdat, 1'b0);
         `CHK(dev.burns, i + 3)
      end
      burn(6'd25, 16'h1234, 1'b0);
      do_op(OTPS_OP_CLEAR, 6'h00, 16'h0000, 1'b0);
      for (i = 9; i <= 12; i++) `CHK(dev.regs[i], 16'h0000)
      foreach (aq[j]) verify(aq[j], exp_otp[aq[j]]);
      verify(6'd25, 16'h1234);
      verify(aq[2], ~exp_otp[aq[2]]);
      // Let the last done pulse be counted
      @(negedge mclk);
      `CHK(dev.viol, 0)
      `CHK(dones, nops)
      final_report();
   end
   initial begin
      // About 16 orders of under 1500 cycles each, with ample margin
      repeat (60000) @(posedge mclk);
      err_total++;
      final_report();
   end
endmodule : tb
